// File: rtl/aisc_regs.svh
// aisc_regs.svh: offsets, fields, reset values and timing of the scaling curves
// assumes a word-addressed register port; point, limit, input and output values are signed, unit 0.00001
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef AISC_REGS_SVH
`define AISC_REGS_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define AISC_VAL_W      48
`define AISC_ADDR_W     11
`define AISC_NUM_CURVES 4
`define AISC_NUM_PTS    20
`define AISC_NUM_SRC    42
`define AISC_SCALE      48'h0186a0

// ----------------------------------------------------------------------------
// register offsets (word index); curve c sits at c * 0x100
// ----------------------------------------------------------------------------
`define AISC_ADDR_GLOBAL 11'h400
`define AISC_OFF_CTRL    8'h00
`define AISC_OFF_TAU     8'h01
`define AISC_OFF_CYCLE   8'h02
`define AISC_OFF_MIN     8'h03
`define AISC_OFF_MAX     8'h04
`define AISC_OFF_USED    8'h05
`define AISC_OFF_INNOW   8'h06
`define AISC_OFF_OUTNOW  8'h07
`define AISC_OFF_STATUS  8'h08
`define AISC_OFF_PTX     8'h20
`define AISC_OFF_PTY     8'h40

// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define AISC_CTL_EN      0
`define AISC_CTL_FILT    1
`define AISC_CTL_RNG     2
`define AISC_CTL_RND_LO  3
`define AISC_CTL_SEL_LO  8

// ----------------------------------------------------------------------------
// reset values and limits; tau and cycle count 5 ms steps
// ----------------------------------------------------------------------------
`define AISC_TAU_RST     20'h000c8
`define AISC_TAU_MAX     20'hb98c0
`define AISC_CYC_RST     11'h01e
`define AISC_CYC_MAX     11'h7d0
`define AISC_USED_BASE   20'h00003

// ----------------------------------------------------------------------------
// timing: 5 ms step at 40 MHz
// ----------------------------------------------------------------------------
`define AISC_STEP_US     5000
`define AISC_CLK_MHZ     40
`define AISC_STEP_CYC    (`AISC_STEP_US * `AISC_CLK_MHZ)

`endif

// File: rtl/aisc_pkg.sv
// aisc_pkg: types shared by the scaling curve block and its users
// assumes aisc_regs.svh is on the include path
package aisc_pkg;
  `include "aisc_regs.svh"

  typedef logic signed [`AISC_VAL_W-1:0] aisc_val_t;

  // one measurement channel; valid low means the signal is lost
  typedef struct packed {
    logic      valid;
    aisc_val_t value;
  } aisc_meas_t;

  // register port request
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`AISC_ADDR_W-1:0] addr;
    aisc_val_t               wdata;
  } aisc_bus_req_t;

  typedef enum logic [1:0] {
    AISC_RND_FLOAT = 2'h0,
    AISC_RND_FLOOR = 2'h1,
    AISC_RND_CEIL  = 2'h2,
    AISC_RND_NEAR  = 2'h3
  } aisc_rnd_t;

  typedef enum logic [3:0] {
    AISC_ST_IDLE = 4'h0,
    AISC_ST_FGO  = 4'h1,
    AISC_ST_FWT  = 4'h3,
    AISC_ST_CHK  = 4'h2,
    AISC_ST_IGO  = 4'h6,
    AISC_ST_IWT  = 4'h7,
    AISC_ST_RGO  = 4'h5,
    AISC_ST_RWT  = 4'h4,
    AISC_ST_DONE = 4'hc
  } aisc_state_t;
endpackage

// File: rtl/aisc_scaling.sv
// aisc_scaling: four analog input scaling curves with filter and range check
// assumes measurement inputs and register port run on sys_clk
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "aisc_regs.svh"
module aisc_scaling #(
  parameter int STEP_CYC = `AISC_STEP_CYC
) (
  input  wire logic                                sys_clk,
  input  wire logic                                resetn,
  input  wire aisc_pkg::aisc_bus_req_t             busReq,
  output logic [`AISC_VAL_W-1:0]                   busRdata,
  input  wire aisc_pkg::aisc_meas_t [`AISC_NUM_SRC-1:0] measIn,
  output logic [`AISC_NUM_SRC-1:0]                 srcActive,
  output aisc_pkg::aisc_val_t [`AISC_NUM_CURVES-1:0] curveInNow,
  output aisc_pkg::aisc_val_t [`AISC_NUM_CURVES-1:0] curveOutNow,
  output logic [`AISC_NUM_CURVES-1:0]              curveValid,
  output logic [`AISC_NUM_CURVES-1:0]              scalingCurveRangeFlag
);
  localparam int NC = `AISC_NUM_CURVES;
  localparam int NP = `AISC_NUM_PTS;
  localparam int SW = $clog2(STEP_CYC);

  // --------------------------------------------------------------------------
  // configuration storage
  // --------------------------------------------------------------------------
  logic                masterReg;
  logic [NC-1:0]       enReg;
  logic [NC-1:0]       filtReg;
  logic [NC-1:0]       rngReg;
  aisc_pkg::aisc_rnd_t rndReg  [NC];
  logic [5:0]          selReg  [NC];
  logic [19:0]         tauReg  [NC];
  logic [10:0]         cycReg  [NC];
  aisc_pkg::aisc_val_t minReg  [NC];
  aisc_pkg::aisc_val_t maxReg  [NC];
  logic [NP-1:0]       usedReg [NC];
  aisc_pkg::aisc_val_t xReg    [NC][NP];
  aisc_pkg::aisc_val_t yReg    [NC][NP];

  // per-curve run state
  aisc_pkg::aisc_val_t fltReg  [NC];
  logic [NC-1:0]       primedReg;
  logic [NC-1:0]       pendReg;
  logic [NC-1:0]       takeReg;
  logic [NC-1:0]       liveCurve;

  // --------------------------------------------------------------------------
  // register port decode
  // --------------------------------------------------------------------------
  wire        isGlob  = busReq.addr == `AISC_ADDR_GLOBAL;
  wire        inCurve = ~busReq.addr[10];
  wire [1:0]  aCur    = busReq.addr[9:8];
  wire [7:0]  aOff    = busReq.addr[7:0];
  wire        isPtX   = inCurve && aOff >= `AISC_OFF_PTX && aOff < `AISC_OFF_PTX + 8'h14;
  wire        isPtY   = inCurve && aOff >= `AISC_OFF_PTY && aOff < `AISC_OFF_PTY + 8'h14;
  wire [7:0]  ptDiff  = isPtX ? aOff - `AISC_OFF_PTX : aOff - `AISC_OFF_PTY;
  wire [4:0]  ptIdx   = ptDiff[4:0];
  wire        wrCur   = busReq.wr && inCurve;
  wire [19:0] wTau    = busReq.wdata[19:0];
  wire [10:0] wCyc    = busReq.wdata[10:0];
  // out-of-range settings are pulled to the nearest legal step
  wire [19:0] tauClip = (wTau == 20'h0) ? 20'h00001 :
                        (wTau > `AISC_TAU_MAX) ? `AISC_TAU_MAX : wTau;
  wire [10:0] cycClip = (wCyc == 11'h0) ? 11'h001 :
                        (wCyc > `AISC_CYC_MAX) ? `AISC_CYC_MAX : wCyc;

  // --------------------------------------------------------------------------
  // read selection
  // --------------------------------------------------------------------------
  wire [`AISC_VAL_W-1:0] ctrlWord = {34'h0, selReg[aCur], 3'h0, rndReg[aCur],
                                     rngReg[aCur], filtReg[aCur], enReg[aCur]};
  wire [`AISC_VAL_W-1:0] rdNext =
    isGlob                       ? {47'h0, masterReg} :
    !inCurve                     ? '0 :
    (aOff == `AISC_OFF_CTRL)     ? ctrlWord :
    (aOff == `AISC_OFF_TAU)      ? {28'h0, tauReg[aCur]} :
    (aOff == `AISC_OFF_CYCLE)    ? {37'h0, cycReg[aCur]} :
    (aOff == `AISC_OFF_MIN)      ? minReg[aCur] :
    (aOff == `AISC_OFF_MAX)      ? maxReg[aCur] :
    (aOff == `AISC_OFF_USED)     ? {28'h0, usedReg[aCur]} :
    (aOff == `AISC_OFF_INNOW)    ? curveInNow[aCur] :
    (aOff == `AISC_OFF_OUTNOW)   ? curveOutNow[aCur] :
    (aOff == `AISC_OFF_STATUS)   ? {46'h0, curveValid[aCur],
                                    scalingCurveRangeFlag[aCur]} :
    isPtX                        ? xReg[aCur][ptIdx] :
    isPtY                        ? yReg[aCur][ptIdx] : '0;

  // read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busRdata <= '0;
    end else begin
      busRdata <= busReq.rd ? rdNext : '0;
    end
  end

  // --------------------------------------------------------------------------
  // configuration writes
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      masterReg <= 1'b0;
      enReg     <= '0;
      filtReg   <= '0;
      rngReg    <= '0;
      for (int c = 0; c < NC; c++) begin
        rndReg[c]  <= aisc_pkg::AISC_RND_FLOAT;
        selReg[c]  <= 6'h00;
        tauReg[c]  <= `AISC_TAU_RST;
        cycReg[c]  <= `AISC_CYC_RST;
        minReg[c]  <= '0;
        maxReg[c]  <= '0;
        usedReg[c] <= `AISC_USED_BASE;
        for (int k = 0; k < NP; k++) begin
          xReg[c][k] <= (k == 1) ? `AISC_SCALE : '0;
          yReg[c][k] <= '0;
        end
      end
    end else begin
      if (busReq.wr && isGlob) begin
        masterReg <= busReq.wdata[0];
      end
      if (wrCur) begin
        case (aOff)
          `AISC_OFF_CTRL: begin
            enReg[aCur]   <= busReq.wdata[`AISC_CTL_EN];
            filtReg[aCur] <= busReq.wdata[`AISC_CTL_FILT];
            rngReg[aCur]  <= busReq.wdata[`AISC_CTL_RNG];
            rndReg[aCur]  <= aisc_pkg::aisc_rnd_t'(busReq.wdata[`AISC_CTL_RND_LO +: 2]);
            selReg[aCur]  <= busReq.wdata[`AISC_CTL_SEL_LO +: 6];
          end
          `AISC_OFF_TAU:   tauReg[aCur] <= tauClip;
          `AISC_OFF_CYCLE: cycReg[aCur] <= cycClip;
          `AISC_OFF_MIN:   minReg[aCur] <= busReq.wdata;
          `AISC_OFF_MAX:   maxReg[aCur] <= busReq.wdata;
          // the two base points can never be switched off
          `AISC_OFF_USED:  usedReg[aCur] <= busReq.wdata[19:0] | `AISC_USED_BASE;
          default: begin
            if (isPtX) begin
              xReg[aCur][ptIdx] <= busReq.wdata;
            end
            if (isPtY) begin
              yReg[aCur][ptIdx] <= busReq.wdata;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // 5 ms step enable and per-curve update timers
  // --------------------------------------------------------------------------
  logic [SW-1:0] stepCnt;
  logic          stepTick;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stepCnt  <= '0;
      stepTick <= 1'b0;
    end else begin
      stepTick <= stepCnt == SW'(STEP_CYC - 1);
      stepCnt  <= (stepCnt == SW'(STEP_CYC - 1)) ? '0 : stepCnt + 1'b1;
    end
  end

  for (genvar c = 0; c < NC; c++) begin : g_timer
    logic [10:0] cycCnt;
    assign liveCurve[c] = masterReg && enReg[c];
    // a new due tick beats the take pulse, so no update is dropped
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        cycCnt     <= '0;
        pendReg[c] <= 1'b0;
      end else if (!liveCurve[c]) begin
        cycCnt     <= '0;
        pendReg[c] <= 1'b0;
      end else if (stepTick && cycCnt >= cycReg[c] - 11'h001) begin
        cycCnt     <= '0;
        pendReg[c] <= 1'b1;
      end else begin
        if (stepTick) begin
          cycCnt <= cycCnt + 11'h001;
        end
        if (takeReg[c]) begin
          pendReg[c] <= 1'b0;
        end
      end
    end
  end

  // sources read by live curves; others may power down their measurement
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      srcActive <= '0;
    end else begin
      for (int s = 0; s < `AISC_NUM_SRC; s++) begin
        srcActive[s] <= 1'b0;
        for (int c = 0; c < NC; c++) begin
          if (liveCurve[c] && selReg[c] == 6'(s)) begin
            srcActive[s] <= 1'b1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // shared serial divider, truncates toward zero
  // --------------------------------------------------------------------------
  logic                divGo;
  logic signed [95:0]  divNum;
  aisc_pkg::aisc_val_t divDen;
  logic [95:0]         divQ;
  logic [48:0]         divRem;
  logic [47:0]         divD;
  logic                divNeg;
  logic [6:0]          divCnt;
  logic                divDone;

  wire [48:0]        remSh = {divRem[47:0], divQ[95]};
  wire               remGe = remSh >= {1'b0, divD};
  wire signed [95:0] divQs = divNeg ? -$signed(divQ) : $signed(divQ);

  // one quotient bit a cycle; 96 cycles is short against the 5 ms step
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divQ <= '0; divRem <= '0; divD <= '0;
      divNeg <= 1'b0; divCnt <= '0; divDone <= 1'b0;
    end else begin
      divDone <= 1'b0;
      if (divGo) begin
        divQ   <= divNum[95] ? 96'(-divNum) : divNum;
        divD   <= divDen[47] ? 48'(-divDen) : divDen;
        divNeg <= divNum[95] ^ divDen[47];
        divRem <= '0;
        divCnt <= 7'h60;
      end else if (divCnt != 7'h00) begin
        divRem  <= remGe ? remSh - {1'b0, divD} : remSh;
        divQ    <= {divQ[94:0], remGe};
        divCnt  <= divCnt - 7'h01;
        divDone <= divCnt == 7'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // sequencer datapath: source pick, segment search, rounding
  // --------------------------------------------------------------------------
  aisc_pkg::aisc_state_t stateReg;
  logic [1:0]            cur;
  aisc_pkg::aisc_val_t   resReg;

  wire [1:0] pick = pendReg[0] ? 2'h0 : pendReg[1] ? 2'h1 : pendReg[2] ? 2'h2 : 2'h3;
  // codes above the last source read as a lost signal
  wire                 selOk   = selReg[cur] < 6'(`AISC_NUM_SRC);
  wire [5:0]           selIdx  = selOk ? selReg[cur] : 6'h00;
  wire                 smpOk   = selOk && measIn[selIdx].valid;
  aisc_pkg::aisc_val_t smpVal;
  assign smpVal = measIn[selIdx].value;
  wire aisc_pkg::aisc_val_t fltDiff = smpVal - fltReg[cur];
  wire [47:0]          fltDen  = 48'(tauReg[cur]) + 48'(cycReg[cur]);

  logic       haveLo;
  logic       haveHi;
  logic [4:0] loIdx;
  logic [4:0] hiIdx;

  // nearest active point at or below the input, and the nearest above it
  always_comb begin
    haveLo = 1'b0;
    haveHi = 1'b0;
    loIdx  = 5'h00;
    hiIdx  = 5'h00;
    for (int k = 0; k < NP; k++) begin
      if (usedReg[cur][k]) begin
        if (xReg[cur][k] <= fltReg[cur] && (!haveLo || xReg[cur][k] > xReg[cur][loIdx])) begin
          haveLo = 1'b1;
          loIdx  = 5'(k);
        end
        if (xReg[cur][k] > fltReg[cur] && (!haveHi || xReg[cur][k] < xReg[cur][hiIdx])) begin
          haveHi = 1'b1;
          hiIdx  = 5'(k);
        end
      end
    end
  end

  wire aisc_pkg::aisc_val_t dx = fltReg[cur] - xReg[cur][loIdx];
  wire aisc_pkg::aisc_val_t dy = yReg[cur][hiIdx] - yReg[cur][loIdx];
  wire aisc_pkg::aisc_val_t qT = divQs[47:0];
  wire       rmNz  = divRem != 49'h0;
  wire       rmHalf = {divRem, 1'b0} >= 50'(`AISC_SCALE);
  wire aisc_pkg::aisc_val_t qAdj =
    (rndReg[cur] == aisc_pkg::AISC_RND_FLOOR && divNeg && rmNz)  ? qT - 1'b1 :
    (rndReg[cur] == aisc_pkg::AISC_RND_CEIL && !divNeg && rmNz)  ? qT + 1'b1 :
    (rndReg[cur] == aisc_pkg::AISC_RND_NEAR && rmHalf)           ?
      (divNeg ? qT - 1'b1 : qT + 1'b1) : qT;
  wire [95:0] rndProd = qAdj * `AISC_SCALE;

  // --------------------------------------------------------------------------
  // sequencer: one curve at a time, sample, filter, check, map, round
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stateReg <= aisc_pkg::AISC_ST_IDLE;
      cur <= 2'h0; resReg <= '0; takeReg <= '0;
      divGo <= 1'b0; divNum <= '0; divDen <= '0;
      primedReg <= '0; curveValid <= '0; scalingCurveRangeFlag <= '0;
      for (int c = 0; c < NC; c++) begin
        fltReg[c] <= '0; curveInNow[c] <= '0; curveOutNow[c] <= '0;
      end
    end else begin
      takeReg <= '0;
      divGo   <= 1'b0;
      case (stateReg)
        aisc_pkg::AISC_ST_IDLE: begin
          if (|pendReg && !(|takeReg)) begin
            cur      <= pick;
            takeReg  <= 4'h1 << pick;
            stateReg <= aisc_pkg::AISC_ST_FGO;
          end
        end
        aisc_pkg::AISC_ST_FGO: begin
          if (!smpOk) begin
            stateReg <= aisc_pkg::AISC_ST_DONE;
          end else if (filtReg[cur] && primedReg[cur]) begin
            curveInNow[cur] <= smpVal;
            divNum   <= 96'(fltDiff) * 96'($signed({1'b0, cycReg[cur]}));
            divDen   <= fltDen;
            divGo    <= 1'b1;
            stateReg <= aisc_pkg::AISC_ST_FWT;
          end else begin
            curveInNow[cur] <= smpVal;
            fltReg[cur]     <= smpVal;
            primedReg[cur]  <= 1'b1;
            stateReg        <= aisc_pkg::AISC_ST_CHK;
          end
        end
        aisc_pkg::AISC_ST_FWT: begin
          if (divDone) begin
            fltReg[cur] <= fltReg[cur] + qT;
            stateReg    <= aisc_pkg::AISC_ST_CHK;
          end
        end
        aisc_pkg::AISC_ST_CHK: begin
          // set follows the filtered value once per update, in the check state; clear also comes there or when the curve is disabled
          scalingCurveRangeFlag[cur] <= rngReg[cur] &&
            (fltReg[cur] < minReg[cur] || fltReg[cur] > maxReg[cur]);
          stateReg <= aisc_pkg::AISC_ST_IGO;
        end
        aisc_pkg::AISC_ST_IGO: begin
          if (!haveLo) begin
            resReg   <= yReg[cur][hiIdx];
            stateReg <= aisc_pkg::AISC_ST_RGO;
          end else if (!haveHi) begin
            resReg   <= yReg[cur][loIdx];
            stateReg <= aisc_pkg::AISC_ST_RGO;
          end else begin
            divNum   <= 96'(dx) * 96'(dy);
            divDen   <= xReg[cur][hiIdx] - xReg[cur][loIdx];
            divGo    <= 1'b1;
            stateReg <= aisc_pkg::AISC_ST_IWT;
          end
        end
        aisc_pkg::AISC_ST_IWT: begin
          if (divDone) begin
            resReg   <= yReg[cur][loIdx] + qT;
            stateReg <= aisc_pkg::AISC_ST_RGO;
          end
        end
        aisc_pkg::AISC_ST_RGO: begin
          if (rndReg[cur] == aisc_pkg::AISC_RND_FLOAT) begin
            curveOutNow[cur] <= resReg;
            stateReg         <= aisc_pkg::AISC_ST_DONE;
          end else begin
            divNum   <= 96'(resReg);
            divDen   <= `AISC_SCALE;
            divGo    <= 1'b1;
            stateReg <= aisc_pkg::AISC_ST_RWT;
          end
        end
        aisc_pkg::AISC_ST_RWT: begin
          if (divDone) begin
            curveOutNow[cur] <= rndProd[47:0];
            stateReg         <= aisc_pkg::AISC_ST_DONE;
          end
        end
        aisc_pkg::AISC_ST_DONE: begin
          curveValid[cur] <= primedReg[cur];
          stateReg        <= aisc_pkg::AISC_ST_IDLE;
        end
        default: stateReg <= aisc_pkg::AISC_ST_IDLE;
      endcase
      // a disabled curve clears its valid, flag and output, keeps curveInNow, and restarts its filter later
      for (int c = 0; c < NC; c++) begin
        if (!liveCurve[c]) begin
          curveValid[c]            <= 1'b0;
          scalingCurveRangeFlag[c] <= 1'b0;
          primedReg[c]             <= 1'b0;
          curveOutNow[c]           <= '0;
        end
      end
    end
  end
endmodule

// File: verif/aisc_scaling_assertions.sv
// aisc_scaling_assertions: port checks of the scaling curves, bound to the design
// assumes aisc_pkg is compiled first and STEP_CYC is at least 9
`timescale 1ns/1ps
`include "aisc_regs.svh"
module aisc_scaling_checker (
  input wire logic                                       sys_clk,
  input wire logic                                       resetn,
  input wire aisc_pkg::aisc_bus_req_t                    busReq,
  input wire logic [`AISC_VAL_W-1:0]                     busRdata,
  input wire logic [`AISC_NUM_SRC-1:0]                   srcActive,
  input wire aisc_pkg::aisc_val_t [`AISC_NUM_CURVES-1:0] curveInNow,
  input wire aisc_pkg::aisc_val_t [`AISC_NUM_CURVES-1:0] curveOutNow,
  input wire logic [`AISC_NUM_CURVES-1:0]                curveValid,
  input wire logic [`AISC_NUM_CURVES-1:0]                scalingCurveRangeFlag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // master off write: data bit 0 low at the global word
  wire masterOff = busReq.wr && busReq.addr == 11'h400 && !busReq.wdata[0];
  reset_state_a: assert property ($rose(resetn) |-> curveValid == '0 && srcActive == '0)
    else $error("outputs not idle after reset");
  master_off_a: assert property (masterOff |-> ##2 curveValid == '0 && curveOutNow == '0)
    else $error("curves still live after master disable");
  src_count_a: assert property ($countones(srcActive) <= 4)
    else $error("more sources measured than curves");
  sample_spacing_a: assert property ($changed(curveInNow[0]) |=> $stable(curveInNow[0]) [*8])
    else $error("input sampled twice within one update step");
  rdata_idle_a: assert property (!$past(busReq.rd) |-> busRdata == '0)
    else $error("read data not zero outside read slot");
  unmapped_read_a: assert property (busReq.rd && busReq.addr == 11'h7ff |=> busRdata == '0)
    else $error("unmapped read not zero");
  status_read_a: assert property (busReq.rd && busReq.addr == 11'h008 |=>
    busRdata[1:0] == $past({curveValid[0], scalingCurveRangeFlag[0]}))
    else $error("status word does not match flag and valid");
  innow_read_a: assert property (busReq.rd && busReq.addr == 11'h006 |=>
    busRdata == $past(curveInNow[0]))
    else $error("input indication differs from port");
  outnow_read_a: assert property (busReq.rd && busReq.addr == 11'h007 |=>
    busRdata == $past(curveOutNow[0]))
    else $error("output indication differs from port");
endmodule
bind aisc_scaling aisc_scaling_checker i_aisc_scaling_checker (.sys_clk, .resetn, .busReq,
  .busRdata, .srcActive, .curveInNow, .curveOutNow, .curveValid, .scalingCurveRangeFlag);

// File: verif/aisc_meas_model.sv
// aisc_meas_model: relay measurement channels feeding the curves
// assumes level and lost change by the bench on sys_clk
`timescale 1ns/1ps
`include "aisc_regs.svh"
module aisc_meas_model (
  input  wire logic                                sys_clk,
  input  wire logic [`AISC_NUM_SRC-1:0]            srcActive,
  input  wire aisc_pkg::aisc_val_t                 level,
  input  wire logic                                lost,
  output aisc_pkg::aisc_meas_t [`AISC_NUM_SRC-1:0] measIn
);
  initial measIn = '0;
  // idle or lost channels toggle junk so a stale value never passes for live data
  always @(posedge sys_clk) begin
    for (int s = 0; s < `AISC_NUM_SRC; s++) begin
      measIn[s].valid <= srcActive[s] && !lost;
      measIn[s].value <= (srcActive[s] && !lost) ? level : ~measIn[s].value;
    end
  end
endmodule

// File: verif/aisc_scaling_tb.sv
// aisc_scaling_tb: register-driven checks of curve 0 against the measurement model
// assumes design, checker and model compile first; step shortened to 16 clocks
`timescale 1ns/1ps
`include "aisc_regs.svh"
module aisc_scaling_tb;
  logic                                    sys_clk, resetn, lost;
  logic [47:0]                             busRdata, rdv;
  aisc_pkg::aisc_bus_req_t                 busReq;
  aisc_pkg::aisc_val_t                     level;
  aisc_pkg::aisc_meas_t [`AISC_NUM_SRC-1:0] measIn;
  logic [`AISC_NUM_SRC-1:0]                srcActive;
  aisc_pkg::aisc_val_t [3:0]               curveInNow, curveOutNow;
  logic [3:0]                              curveValid, flag;
  int                                      n_mismatch = 0, tests_run = 0;
  aisc_scaling #(.STEP_CYC(16)) i_aisc_scaling (.sys_clk, .resetn, .busReq, .busRdata,
    .measIn, .srcActive, .curveInNow, .curveOutNow, .curveValid, .scalingCurveRangeFlag(flag));
  aisc_meas_model i_aisc_meas_model (.sys_clk, .srcActive, .level, .lost, .measIn);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string what, logic [47:0] exp, logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // one strobe; read data taken 1 ns after the edge while it stands, then an idle edge
  task automatic acc(logic w, logic [10:0] a, logic [47:0] d);
    busReq <= '{w, !w, a, d};
    @(posedge sys_clk);
    busReq <= '0;
    #1 rdv = busRdata;
    @(posedge sys_clk);
  endtask
  task automatic rdc(string what, logic [10:0] a, logic [47:0] exp);
    acc(1'b0, a, 48'h0);
    check(what, exp, rdv);
  endtask
  // poll mid-cycle for the scaled output, bounded well past one update
  task automatic waitOut(logic [47:0] exp, logic f);
    int i;
    for (i = 0; i < 1000 && curveOutNow[0] !== exp; i++) @(negedge sys_clk);
    check("out", exp, curveOutNow[0]);
    check("flag", f, flag[0]);
    if (i == 1000) test_done();
    else @(posedge sys_clk);
  endtask
  initial begin
    logic [47:0] rndExp [3] = '{48'h186a0, 48'h0, 48'h186a0};
    logic [47:0] rndCode [3] = '{48'h2, 48'h1, 48'h3};
    resetn = 1'b0;
    busReq = '0;
    level = 48'h0;
    lost = 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdc("master", 11'h400, 48'h0);
    rdc("ctrl", 11'h000, 48'h0);
    rdc("tau", 11'h001, 48'hc8);
    rdc("cycle", 11'h002, 48'h1e);
    rdc("used", 11'h005, 48'h3);
    rdc("x2", 11'h021, 48'h186a0);
    rdc("hole", 11'h7ff, 48'h0);
    acc(1'b1, 11'h001, 48'h0);
    rdc("tauMin", 11'h001, 48'h1);
    acc(1'b1, 11'h002, 48'h0);
    rdc("cycMin", 11'h002, 48'h1);
    acc(1'b1, 11'h041, 48'h30d40);
    acc(1'b1, 11'h004, 48'h186a0);
    acc(1'b1, 11'h000, 48'h505);
    level <= 48'h7530;
    acc(1'b1, 11'h400, 48'h1);
    waitOut(48'hea60, 1'b0);
    check("srcSel", 48'h1, srcActive[5]);
    check("inNow", 48'h7530, curveInNow[0]);
    rdc("outReg", 11'h007, 48'hea60);
    level <= 48'h249f0;
    waitOut(48'h30d40, 1'b1);
    rdc("status", 11'h008, 48'h3);
    rdc("inReg", 11'h006, 48'h249f0);
    lost <= 1'b1;
    level <= 48'h4e20;
    repeat (200) @(posedge sys_clk);
    check("held", 48'h249f0, curveInNow[0]);
    check("heldOut", 48'h30d40, curveOutNow[0]);
    lost <= 1'b0;
    waitOut(48'h9c40, 1'b0);
    level <= 48'h7530;
    for (int k = 0; k < 3; k++) begin
      acc(1'b1, 11'h000, 48'h505 | (rndCode[k] << 3));
      waitOut(rndExp[k], 1'b0);
    end
    // filter on, tau 1 step against a 1-step cycle: f moves half the gap per update
    acc(1'b1, 11'h001, 48'h1);
    acc(1'b1, 11'h000, 48'h507);
    level <= 48'h11170;
    waitOut(48'h1d4c0, 1'b0);
    waitOut(48'h1fbd0, 1'b0);
    acc(1'b1, 11'h400, 48'h0);
    repeat (2) @(posedge sys_clk);
    check("validOff", 48'h0, curveValid[0]);
    check("srcOff", 48'h0, srcActive);
    test_done();
  end
endmodule
